// file: inc/lpm_pkg.sv
// package: modes, register offsets, field positions and reset values
package lpm_pkg;

   // chip power modes, binary coded
   typedef enum logic [3:0] {
      MODE_RUN       = 4'h0,
      MODE_VLP_RUN   = 4'h1,
      MODE_WAIT      = 4'h2,
      MODE_STOP      = 4'h3,
      MODE_VLP_WAIT  = 4'h4,
      MODE_VLP_STOP  = 4'h5,
      MODE_LL_STOP   = 4'h6,
      MODE_LKG_3     = 4'h7,
      MODE_LKG_2     = 4'h8,
      MODE_LKG_1     = 4'h9,
      MODE_BACKUP    = 4'hA
   } mode_t;

   // register byte offsets
   localparam logic [7:0] CTRL_OFFS = 8'h00;
   localparam logic [7:0] STAT_OFFS = 8'h04;
   localparam logic [7:0] WAKE_OFFS = 8'h08;

   // control register fields
   localparam int TARGET_LSB = 0;
   localparam int SLOW_RUN_BIT = 4;
   localparam logic [3:0] TARGET_RST = 4'h2;

   // wake register fields
   localparam int WAKE_FLAG_BIT = 0;
   localparam int WAKE_RST_BIT = 1;

   // clock rates in MHz
   localparam int SYS_CLK_MHZ = 100;
   localparam int FLASH_SLOW_MHZ = 1;
   localparam int LP_OSC_MHZ = 2;
   localparam int FLASH_DIV = SYS_CLK_MHZ / FLASH_SLOW_MHZ;
   localparam int LP_DIV = SYS_CLK_MHZ / LP_OSC_MHZ;

   // cycles the reset request is held on a reset-path wake-up
   localparam int WAKE_RST_CYC = 16;

endpackage : lpm_pkg

// file: logic/lpm_axil_slave.sv
// axi4-lite slave holding the control register, serving status and wake
`timescale 1ns/100ps
module lpm_axil_slave
   import lpm_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] stat_in,
   input wire logic wake_flag_in,
   output logic [4:0] ctrl_r,
   output logic wake_clr
);
   logic aw_got_r;
   logic w_got_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic do_wr;

   assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
   assign s_axi_wready = !w_got_r && !s_axi_bvalid;
   assign do_wr = aw_got_r && w_got_r && !s_axi_bvalid;

   // address and data latched independently, in either order
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
      end else if (do_wr) begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
      end
   end

   // register write and write response
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ctrl_r <= {1'b0, TARGET_RST};
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= 2'h0;
            if (awaddr_r[7:2] == CTRL_OFFS[7:2]) begin
               if (wstrb_r[0]) begin
                  ctrl_r <= wdata_r[4:0];
               end
            end else if (awaddr_r[7:2] != WAKE_OFFS[7:2] &&
                         awaddr_r[7:2] != STAT_OFFS[7:2]) begin
               s_axi_bresp <= 2'h2; // unmapped: slverr
            end
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // write-one-to-clear of the wake flag, one-cycle pulse
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         wake_clr <= 1'b0;
      end else begin
         wake_clr <= do_wr && awaddr_r[7:2] == WAKE_OFFS[7:2] &&
                     wstrb_r[0] && wdata_r[WAKE_FLAG_BIT];
      end
   end

   assign s_axi_arready = !s_axi_rvalid;

   // read path, answer one cycle after address is taken
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= 2'h0;
         case (s_axi_araddr[7:2])
            CTRL_OFFS[7:2]: s_axi_rdata <= {27'h0, ctrl_r};
            STAT_OFFS[7:2]: s_axi_rdata <= stat_in;
            WAKE_OFFS[7:2]: s_axi_rdata <= {31'h0, wake_flag_in};
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= 2'h2;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule : lpm_axil_slave

// file: logic/lpm_clk_div.sv
// enable-pulse generator dividing the system clock by a parameter
`timescale 1ns/100ps
module lpm_clk_div #(
   parameter int DIV = 50
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   output logic tick_r
);
   logic [$clog2(DIV)-1:0] cnt_r;

   // free-running counter, one tick each DIV cycles
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cnt_r <= '0;
         tick_r <= 1'b0;
      end else if (cnt_r == $bits(cnt_r)'(DIV - 1)) begin
         cnt_r <= '0;
         tick_r <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 1'b1;
         tick_r <= 1'b0;
      end
   end
endmodule : lpm_clk_div

// file: logic/low_power_mode_sequencer.sv
// low-power mode sequencer: mode state machine and power/clock controls
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
// Functional notes
// RL1 - slow run: flash 1 MHz, voltage detect off
// RL2 - slow run clocks from 2 MHz oscillator
// RL3 - slow wait: core sleeps, any irq runs
// RL4 - slow stop: clocks stopped, async wake controller
// RL5 - slow stop: detect off, listed peripherals, retention
// RL6 - leakage stop wakes through wake-unit isr
// RL7 - software keeps wake-unit interrupt unmasked
// RL8 - level stops wake via reset, flag set
// RL9 - level three keeps both sram blocks
// RL10 - level two: lower off, upper partial
// RL11 - level one: only register files kept
// RL12 - backup state: rtc, backup file; power-up (code turns lp_periph_en_r and reg_file_pwr_r off in backup)
// RL13 - wait-for-irq instruction enters wait/stop
// RL14 - software target mode chooses entered state
module low_power_mode_sequencer
   import lpm_pkg::*;
#(
   parameter int RST_CYC = WAKE_RST_CYC
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic wait_for_irq_instr,
   input wire logic irq_pending,
   input wire logic wake_event,
   input wire logic power_good,
   output logic core_clk_en_r,
   output logic periph_clk_en_r,
   output logic lp_osc_sel_r,
   output logic clk_tick_r,
   output logic flash_slow_r,
   output logic flash_tick_r,
   output logic low_voltage_detect_en_r,
   output logic nested_irq_ctrl_en_r,
   output logic async_wake_irq_ctrl_en_r,
   output logic leakage_wakeup_unit_en_r,
   output logic lp_periph_en_r,
   output logic sram_upper_pwr_r,
   output logic sram_upper_part_pwr_r,
   output logic sram_lower_pwr_r,
   output logic reg_file_pwr_r,
   output logic main_pwr_r,
   output logic wake_irq_r,
   output logic wake_rst_req_r,
   output logic core_deep_sleep_r,
   output logic core_sleep_r
);
   mode_t mode_r;
   mode_t mode_nxt;
   mode_t run_mode;
   logic [4:0] ctrl_r;
   logic wake_clr;
   logic lp_tick;
   logic fl_tick;
   logic [7:0] rst_cnt_r;
   logic [31:0] stat;
   logic leak_stop;

   // register slave; control steers targets, status shows mode
   lpm_axil_slave u_regs (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .stat_in(stat),
      .wake_flag_in(wake_irq_r),
      .ctrl_r(ctrl_r),
      .wake_clr(wake_clr)
   );

   // 2 MHz tick standing in for the low-power oscillator
   lpm_clk_div #(.DIV(LP_DIV)) u_lp_div (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .tick_r(lp_tick)
   );

   // 1 MHz flash access tick for the slow flash mode
   lpm_clk_div #(.DIV(FLASH_DIV)) u_fl_div (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .tick_r(fl_tick)
   );

   assign stat = {20'h0, wake_rst_req_r, power_good, main_pwr_r,
                  core_clk_en_r, 4'h0, mode_r};
   assign run_mode = ctrl_r[SLOW_RUN_BIT] ? MODE_VLP_RUN : MODE_RUN;
   assign leak_stop = mode_r == MODE_LL_STOP || mode_r == MODE_LKG_3 ||
                      mode_r == MODE_LKG_2 || mode_r == MODE_LKG_1;

   // mode transitions
   always_comb begin
      mode_nxt = mode_r;
      case (mode_r)
         MODE_RUN, MODE_VLP_RUN: begin
            // target only sampled at instruction, so late writes are safe
            if (wait_for_irq_instr) begin // RL13
               case (mode_t'(ctrl_r[3:0])) // RL14
                  MODE_WAIT, MODE_STOP, MODE_LL_STOP, MODE_LKG_3,
                  MODE_LKG_2, MODE_LKG_1, MODE_BACKUP, MODE_VLP_WAIT,
                  MODE_VLP_STOP:
                     mode_nxt = mode_t'(ctrl_r[3:0]);
                  default: mode_nxt = MODE_WAIT;
               endcase
            end else begin
               mode_nxt = run_mode;
            end
         end
         MODE_WAIT, MODE_STOP: begin
            if (irq_pending) mode_nxt = MODE_RUN;
         end
         MODE_VLP_WAIT, MODE_VLP_STOP: begin
            if (irq_pending) mode_nxt = MODE_VLP_RUN; // RL3 RL4
         end
         MODE_LL_STOP: begin
            if (wake_event) mode_nxt = MODE_RUN; // RL6
         end
         MODE_LKG_3, MODE_LKG_2, MODE_LKG_1: begin
            if (wake_event) mode_nxt = MODE_RUN; // RL8
         end
         MODE_BACKUP: begin
            // only a returning main supply brings the chip back
            if (power_good) mode_nxt = MODE_RUN; // RL12
         end
         default: mode_nxt = MODE_RUN;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         mode_r <= MODE_RUN;
      end else begin
         mode_r <= mode_nxt;
      end
   end

   // wake flag: set wins over software clear
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         wake_irq_r <= 1'b0;
      end else if (leak_stop && wake_event) begin
         wake_irq_r <= 1'b1; // RL6 RL8
      end else if (wake_clr) begin
         wake_irq_r <= 1'b0;
      end
   end

   // reset request held for a fixed count after a level-stop or backup wake
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rst_cnt_r <= 8'h00;
         wake_rst_req_r <= 1'b0;
      end else if ((mode_r == MODE_LKG_3 || mode_r == MODE_LKG_2 ||
                    mode_r == MODE_LKG_1) && wake_event) begin
         rst_cnt_r <= 8'(RST_CYC - 1);
         wake_rst_req_r <= 1'b1; // RL8
      end else if (mode_r == MODE_BACKUP && power_good) begin
         rst_cnt_r <= 8'(RST_CYC - 1);
         wake_rst_req_r <= 1'b1; // RL12
      end else if (rst_cnt_r != 8'h00) begin
         rst_cnt_r <= rst_cnt_r - 8'h01;
      end else begin
         wake_rst_req_r <= 1'b0;
      end
   end

   // clocks and clock source
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         core_clk_en_r <= 1'b1;
         periph_clk_en_r <= 1'b1;
         lp_osc_sel_r <= 1'b0;
         clk_tick_r <= 1'b1;
         core_sleep_r <= 1'b0;
         core_deep_sleep_r <= 1'b0;
      end else begin
         core_clk_en_r <= mode_nxt == MODE_RUN || mode_nxt == MODE_WAIT ||
                          mode_nxt == MODE_VLP_RUN ||
                          mode_nxt == MODE_VLP_WAIT; // RL3 RL4
         periph_clk_en_r <= mode_nxt == MODE_RUN ||
                            mode_nxt == MODE_WAIT ||
                            mode_nxt == MODE_VLP_RUN ||
                            mode_nxt == MODE_VLP_WAIT; // RL4 RL9
         lp_osc_sel_r <= mode_nxt == MODE_VLP_RUN ||
                         mode_nxt == MODE_VLP_WAIT; // RL2 RL3
         // in slow run and slow wait the clock tick follows the 2 MHz tick; flash uses its 1 MHz tick
         clk_tick_r <= (mode_nxt == MODE_VLP_RUN ||
                        mode_nxt == MODE_VLP_WAIT) ? lp_tick : 1'b1; // RL2
         core_sleep_r <= mode_nxt == MODE_WAIT ||
                         mode_nxt == MODE_VLP_WAIT; // RL3
         core_deep_sleep_r <= mode_nxt == MODE_STOP ||
                              mode_nxt == MODE_VLP_STOP ||
                              mode_nxt == MODE_LL_STOP ||
                              mode_nxt == MODE_LKG_3 ||
                              mode_nxt == MODE_LKG_2 ||
                              mode_nxt == MODE_LKG_1; // RL4
      end
   end

   // flash mode, voltage detect, interrupt paths, peripherals
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         flash_slow_r <= 1'b0;
         flash_tick_r <= 1'b1;
         low_voltage_detect_en_r <= 1'b1;
         nested_irq_ctrl_en_r <= 1'b1;
         async_wake_irq_ctrl_en_r <= 1'b0;
         leakage_wakeup_unit_en_r <= 1'b0;
         lp_periph_en_r <= 1'b1;
      end else begin
         flash_slow_r <= mode_nxt == MODE_VLP_RUN ||
                         mode_nxt == MODE_VLP_WAIT; // RL1 RL3
         flash_tick_r <= (mode_nxt == MODE_VLP_RUN ||
                          mode_nxt == MODE_VLP_WAIT) ? fl_tick : 1'b1; // RL1
         // detector kept in normal stop, off in all slow modes
         low_voltage_detect_en_r <= mode_nxt == MODE_RUN ||
                                    mode_nxt == MODE_WAIT ||
                                    mode_nxt == MODE_STOP; // RL1 RL5
         nested_irq_ctrl_en_r <= mode_nxt == MODE_RUN ||
                                 mode_nxt == MODE_WAIT ||
                                 mode_nxt == MODE_VLP_RUN ||
                                 mode_nxt == MODE_VLP_WAIT; // RL3 RL4
         async_wake_irq_ctrl_en_r <= mode_nxt == MODE_STOP ||
                                     mode_nxt == MODE_VLP_STOP; // RL4
         leakage_wakeup_unit_en_r <= mode_nxt == MODE_LL_STOP ||
                                     mode_nxt == MODE_LKG_3 ||
                                     mode_nxt == MODE_LKG_2 ||
                                     mode_nxt == MODE_LKG_1; // RL6
         // timer, rtc, comparator, touch, dac, converter usable
         lp_periph_en_r <= mode_nxt != MODE_BACKUP; // RL5 RL9
      end
   end

   // power domains and memory retention
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         sram_upper_pwr_r <= 1'b1;
         sram_upper_part_pwr_r <= 1'b1;
         sram_lower_pwr_r <= 1'b1;
         reg_file_pwr_r <= 1'b1;
         main_pwr_r <= 1'b1;
      end else begin
         sram_upper_pwr_r <= !(mode_nxt == MODE_LKG_2 ||
                               mode_nxt == MODE_LKG_1 ||
                               mode_nxt == MODE_BACKUP); // RL9 RL10
         sram_upper_part_pwr_r <= !(mode_nxt == MODE_LKG_1 ||
                                    mode_nxt == MODE_BACKUP); // RL10 RL11
         sram_lower_pwr_r <= !(mode_nxt == MODE_LKG_2 ||
                               mode_nxt == MODE_LKG_1 ||
                               mode_nxt == MODE_BACKUP); // RL10 RL11
         reg_file_pwr_r <= mode_nxt != MODE_BACKUP; // RL11 RL12
         main_pwr_r <= mode_nxt != MODE_BACKUP; // RL12
      end
   end
endmodule : low_power_mode_sequencer

// file: verif/lpm_partner.sv
// model of the core, interrupt controller and wake-up unit
`timescale 1ns/100ps
module lpm_partner (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic sleep_req,
   input wire logic irq_req,
   input wire logic wake_req,
   input wire logic pwr_req,
   input wire logic wake_irq_r,
   output logic wait_for_irq_instr,
   output logic irq_pending,
   output logic wake_event,
   output logic power_good
);
   // core: the sleep instruction leaves as a one-cycle pulse
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         wait_for_irq_instr <= 1'b0;
      end else begin
         wait_for_irq_instr <= sleep_req;
      end
   end
   // wake flag stays unmasked, else a recovery could hang half-way
   always_ff @(posedge ref_clk) begin
      irq_pending <= irq_req | wake_irq_r;
   end
   // wake unit pin event and main supply monitor
   always_ff @(posedge ref_clk) begin
      wake_event <= wake_req;
      power_good <= pwr_req;
   end
endmodule : lpm_partner

// file: verif/low_power_mode_sequencer_asserts.sv
// checker: port-level properties of the mode sequencer
`timescale 1ns/100ps
module lpm_checker #(
   parameter int RST_CYC = 16
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic wait_for_irq_instr,
   input wire logic irq_pending,
   input wire logic wake_event,
   input wire logic core_clk_en_r,
   input wire logic periph_clk_en_r,
   input wire logic lp_osc_sel_r,
   input wire logic clk_tick_r,
   input wire logic flash_slow_r,
   input wire logic low_voltage_detect_en_r,
   input wire logic nested_irq_ctrl_en_r,
   input wire logic async_wake_irq_ctrl_en_r,
   input wire logic leakage_wakeup_unit_en_r,
   input wire logic lp_periph_en_r,
   input wire logic sram_upper_pwr_r,
   input wire logic sram_lower_pwr_r,
   input wire logic main_pwr_r,
   input wire logic wake_irq_r,
   input wire logic wake_rst_req_r,
   input wire logic core_deep_sleep_r,
   input wire logic core_sleep_r
);
   logic [7:0] hi_cnt_r;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // length of the reset request, judged when it drops
   always_ff @(posedge ref_clk) begin
      if (!rst_n || !wake_rst_req_r) begin
         hi_cnt_r <= 8'h00;
      end else begin
         hi_cnt_r <= hi_cnt_r + 8'h01;
      end
   end
   flash_detect_a: assert property (flash_slow_r |->
      !low_voltage_detect_en_r) else $error("detector on in slow flash");
   slow_tick_a: assert property ((lp_osc_sel_r && core_clk_en_r &&
      clk_tick_r) ##1 (lp_osc_sel_r && core_clk_en_r) |-> !clk_tick_r)
      else $error("slow clock tick lasted two cycles");
   sleep_sense_a: assert property (core_sleep_r |-> core_clk_en_r &&
      nested_irq_ctrl_en_r) else $error("sleep lost clock or irq ctrl");
   wait_wake_a: assert property (core_sleep_r && irq_pending |=>
      !core_sleep_r) else $error("interrupt did not end wait");
   stop_clk_a: assert property (async_wake_irq_ctrl_en_r |->
      !core_clk_en_r && !periph_clk_en_r && !nested_irq_ctrl_en_r)
      else $error("clocks running in stop");
   stop_keep_a: assert property (async_wake_irq_ctrl_en_r &&
      !low_voltage_detect_en_r |-> lp_periph_en_r && sram_upper_pwr_r)
      else $error("slow stop lost retention");
   ll_wake_a: assert property (leakage_wakeup_unit_en_r &&
      wake_event |=> wake_irq_r) else $error("wake flag not set");
   rst_len_a: assert property ($fell(wake_rst_req_r) |->
      hi_cnt_r == 8'(RST_CYC)) else $error("reset request length wrong");
   rst_flag_a: assert property ($rose(wake_rst_req_r) &&
      $past(wake_event) |-> wake_irq_r) else $error("flag clear at reset");
   sram_pair_a: assert property (sram_upper_pwr_r ==
      sram_lower_pwr_r) else $error("upper full with lower off");
   backup_off_a: assert property (!main_pwr_r |-> !core_clk_en_r &&
      !lp_periph_en_r && !sram_lower_pwr_r) else $error("backup not off");
   sleep_entry_a: assert property (wait_for_irq_instr && !core_sleep_r &&
      !core_deep_sleep_r && main_pwr_r && !wake_rst_req_r |=>
      core_sleep_r || core_deep_sleep_r || !main_pwr_r)
      else $error("sleep instruction ignored");
endmodule : lpm_checker

bind low_power_mode_sequencer lpm_checker #(.RST_CYC(RST_CYC)) i_lpm_checker (
   .*);

// file: verif/tb_low_power_mode_sequencer.sv
// self-checking bench for the low-power mode sequencer
`timescale 1ns/100ps
module tb_low_power_mode_sequencer;
   import lpm_pkg::*;
   localparam int RST_CYC = 4;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [31:0] s_axi_rdata, d;
   logic wait_for_irq_instr, irq_pending, wake_event, power_good;
   logic core_clk_en_r, periph_clk_en_r, lp_osc_sel_r, clk_tick_r;
   logic flash_slow_r, flash_tick_r, low_voltage_detect_en_r;
   logic nested_irq_ctrl_en_r, async_wake_irq_ctrl_en_r;
   logic leakage_wakeup_unit_en_r, lp_periph_en_r, sram_upper_pwr_r;
   logic sram_upper_part_pwr_r, sram_lower_pwr_r, reg_file_pwr_r;
   logic main_pwr_r, wake_irq_r, wake_rst_req_r, core_deep_sleep_r;
   logic core_sleep_r;
   logic [3:0] req = 4'h8; // sleep, irq, wake, supply
   int fails = 0, n_checks = 0, cyc = 0;
   // clock and sleep state gathered for compact compares
   wire [7:0] pwr = {core_clk_en_r, periph_clk_en_r, nested_irq_ctrl_en_r,
      async_wake_irq_ctrl_en_r, leakage_wakeup_unit_en_r, core_sleep_r,
      core_deep_sleep_r, low_voltage_detect_en_r};
   wire [7:0] mem = {lp_osc_sel_r, flash_slow_r, lp_periph_en_r,
      sram_upper_pwr_r, sram_upper_part_pwr_r, sram_lower_pwr_r,
      reg_file_pwr_r, main_pwr_r};

   low_power_mode_sequencer #(.RST_CYC(RST_CYC)) i_low_power_mode_sequencer (
      .*);
   lpm_partner i_lpm_partner (.ref_clk, .rst_n, .sleep_req(req[0]),
      .irq_req(req[1]), .wake_req(req[2]), .pwr_req(req[3]), .wake_irq_r,
      .wait_for_irq_instr, .irq_pending, .wake_event, .power_good);

   always #5 ref_clk = ~ref_clk;
   // hang guard, well above the length of the whole run
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         test_done();
      end
   end

   task automatic test_done();
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk8

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk32

   task automatic settle(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : settle

   // one-cycle request to the partner, then time for the mode to land
   task automatic pulse(input int k);
      @(posedge ref_clk);
      req[k] <= 1'b1;
      @(posedge ref_clk);
      req[k] <= 1'b0;
      settle(3);
   endtask : pulse

   // address and data offered together, each dropped once taken
   task automatic axw(input logic [7:0] a, input logic [31:0] v,
      output logic [1:0] b);
      logic ah, wh;
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge ref_clk);
         ah = s_axi_awvalid & s_axi_awready;
         wh = s_axi_wvalid & s_axi_wready;
         @(posedge ref_clk);
         if (ah) s_axi_awvalid <= 1'b0;
         if (wh) s_axi_wvalid <= 1'b0;
      end while (s_axi_awvalid | s_axi_wvalid);
      do @(negedge ref_clk); while (!s_axi_bvalid);
      b = s_axi_bresp;
      @(posedge ref_clk);
      s_axi_bready <= 1'b0;
   endtask : axw

   task automatic axr(input logic [7:0] a, output logic [31:0] v,
      output logic [1:0] e);
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(negedge ref_clk); while (!s_axi_arready);
      @(posedge ref_clk);
      s_axi_arvalid <= 1'b0;
      do @(negedge ref_clk); while (!s_axi_rvalid);
      v = s_axi_rdata;
      e = s_axi_rresp;
      @(posedge ref_clk);
      s_axi_rready <= 1'b0;
   endtask : axr

   task automatic t_regs();
      axr(CTRL_OFFS, d, r);
      chk32(d, {28'h0, TARGET_RST});
      axr(8'h0C, d, r);
      chk32(d, 32'h0);
      chk8({6'h0, r}, 8'h02);
      axw(8'h0C, 32'hFFFF_FFFF, r);
      chk8({6'h0, r}, 8'h02);
   endtask : t_regs

   task automatic t_wait();
      pulse(0);
      chk8(pwr, 8'hE5);
      pulse(1);
      chk8(pwr, 8'hE1);
   endtask : t_wait

   task automatic t_slow();
      logic [7:0] nt = 8'h00, nf = 8'h00;
      axw(CTRL_OFFS, 32'h14, r);
      settle(3);
      chk8(pwr, 8'hE0);
      chk8(mem, 8'hFF);
      // any 100-cycle window holds a fixed number of strobes
      repeat (100) begin
         @(negedge ref_clk);
         nt = nt + {7'h0, clk_tick_r};
         nf = nf + {7'h0, flash_tick_r};
      end
      chk8(nt, 8'(100 / LP_DIV));
      chk8(nf, 8'(100 / FLASH_DIV));
      pulse(0);
      chk8(pwr, 8'hE4);
      chk8(mem, 8'hFF);
      axr(STAT_OFFS, d, r);
      chk32(d & 32'hF, 32'(MODE_VLP_WAIT));
      pulse(1);
      chk8(pwr, 8'hE0);
   endtask : t_slow

   task automatic t_vstop();
      axw(CTRL_OFFS, 32'h15, r);
      pulse(0);
      chk8(pwr, 8'h12);
      chk8(mem & 8'h3F, 8'h3F);
      pulse(1);
      chk8(pwr, 8'hE0);
   endtask : t_vstop

   task automatic t_ll();
      axw(CTRL_OFFS, 32'h06, r);
      settle(3);
      chk8(pwr, 8'hE1);
      pulse(0);
      chk8(pwr, 8'h0A);
      chk8(mem & 8'h3F, 8'h3F);
      pulse(2);
      chk8({6'h0, wake_irq_r, wake_rst_req_r}, 8'h02);
      axr(WAKE_OFFS, d, r);
      chk32(d, 32'h1);
      chk8(pwr, 8'hE1);
      axw(WAKE_OFFS, 32'h1, r);
      settle(3);
      chk8({7'h0, wake_irq_r}, 8'h00);
   endtask : t_ll

   // three leakage levels: only the memory that each level keeps differs
   task automatic t_lvl();
      logic [7:0] mk [3] = '{8'h36, 8'h3E, 8'h3E};
      logic [7:0] ex [3] = '{8'h36, 8'h2A, 8'h22};
      for (int k = 0; k < 3; k++) begin
         axw(CTRL_OFFS, 32'(7 + k), r);
         pulse(0);
         chk8(pwr, 8'h0A);
         chk8(mem & mk[k], ex[k]);
         pulse(2);
         chk8({6'h0, wake_irq_r, wake_rst_req_r}, 8'h03);
         settle(RST_CYC + 1);
         chk8({6'h0, wake_irq_r, wake_rst_req_r}, 8'h02);
         chk8(pwr, 8'hE1);
         axw(WAKE_OFFS, 32'h1, r);
         settle(3);
      end
   endtask : t_lvl

   task automatic t_bak();
      @(posedge ref_clk);
      req[3] <= 1'b0;
      axw(CTRL_OFFS, 32'h0A, r);
      pulse(0);
      chk8(mem & 8'h3D, 8'h00);
      chk8(pwr & 8'hC0, 8'h00);
      @(posedge ref_clk);
      req[3] <= 1'b1;
      settle(RST_CYC + 4);
      chk8(mem, 8'h3F);
      chk8(pwr, 8'hE1);
   endtask : t_bak

   initial begin
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_regs();
      t_wait();
      t_slow();
      t_vstop();
      t_ll();
      t_lvl();
      t_bak();
      test_done();
   end
endmodule : tb_low_power_mode_sequencer
